// >>> logic/iybcs_params.svh
// Constants of the indexed-Y bus-cycle sequencer: opcodes, addresses and cycle counts.
// Assumes it is included by the package and by the sequencer, each by its bare name.
`ifndef IYBCS_PARAMS_SVH
`define IYBCS_PARAMS_SVH

`define IYBCS_PREBYTE 8'h18
`define IYBCS_OP_JUMP 8'h6e
`define IYBCS_OP_TEST 8'h6d
`define IYBCS_OP_CALL 8'had
`define IYBCS_OP_BIT_SET 8'h1c
`define IYBCS_OP_BIT_CLEAR 8'h1d
`define IYBCS_OP_BR_SET 8'h1e
`define IYBCS_OP_BR_CLEAR 8'h1f
`define IYBCS_IDLE_ADDR 16'hffff
`define IYBCS_LEN_JUMP 4'h4
`define IYBCS_LEN_SHORT 4'h5
`define IYBCS_LEN_WORD 4'h6
`define IYBCS_LEN_LONG 4'h7
`define IYBCS_LEN_BIT 4'h8
`define IYBCS_STEP_SHORT 16'h0003
`define IYBCS_STEP_BITMOD 16'h0004
`define IYBCS_STEP_BRANCH 16'h0005

`endif

// >>> logic/iybcs_pkg.sv
// Types and opcode decoding shared by the indexed-Y bus-cycle sequencer.
// Assumes the constants header is on the include path.
`default_nettype none
`include "iybcs_params.svh"

package iybcs_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } iybcs_state_t;

  typedef enum logic [3:0] {
    GRP_BAD, GRP_JUMP, GRP_READ8, GRP_RMW, GRP_TEST, GRP_ST8, GRP_LD16,
    GRP_ST16, GRP_ALU16, GRP_CALL, GRP_BITMOD, GRP_BRBIT
  } iybcs_grp_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rw;
    logic [7:0] wdata;
    logic oe;
  } iybcs_bus_t;

  // Only the second opcode bytes that use the Y-indexed mode are recognised.
  function automatic iybcs_grp_t iybcs_decode(input logic [7:0] op);
    iybcs_grp_t g;
    g = GRP_BAD;
    case (op)
      `IYBCS_OP_JUMP: g = GRP_JUMP;
      `IYBCS_OP_TEST: g = GRP_TEST;
      `IYBCS_OP_CALL: g = GRP_CALL;
      `IYBCS_OP_BIT_SET, `IYBCS_OP_BIT_CLEAR: g = GRP_BITMOD;
      `IYBCS_OP_BR_SET, `IYBCS_OP_BR_CLEAR: g = GRP_BRBIT;
      8'h60, 8'h63, 8'h64, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6c, 8'h6f: g = GRP_RMW;
      8'ha3, 8'he3, 8'hac: g = GRP_ALU16;
      8'hae, 8'hec, 8'hee: g = GRP_LD16;
      8'haf, 8'hed, 8'hef: g = GRP_ST16;
      8'ha7, 8'he7: g = GRP_ST8;
      default: begin
        if ((op[7:4] == 4'ha || op[7:4] == 4'he) && op[3:0] <= 4'hb) begin
          g = GRP_READ8;
        end
      end
    endcase
    return g;
  endfunction

  function automatic logic [3:0] iybcs_len(input iybcs_grp_t g);
    logic [3:0] n;
    n = `IYBCS_LEN_BIT;
    case (g)
      GRP_JUMP: n = `IYBCS_LEN_JUMP;
      GRP_READ8, GRP_ST8: n = `IYBCS_LEN_SHORT;
      GRP_LD16, GRP_ST16: n = `IYBCS_LEN_WORD;
      GRP_RMW, GRP_TEST, GRP_ALU16, GRP_CALL: n = `IYBCS_LEN_LONG;
      default: n = `IYBCS_LEN_BIT;
    endcase
    return n;
  endfunction

endpackage

`default_nettype wire

// >>> logic/iybcs_seq.sv
// Bus-cycle sequencer for Y-indexed instructions: one bus cycle per clock.
// Assumes memory answers on data_i in the same cycle, synchronous to clk_i,
// and that an execution unit supplies store data and read-modify-write results.
`timescale 1ns/1ns
`default_nettype none
`include "iybcs_params.svh"

module iybcs_seq
  import iybcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] index_register_y_i,
  input wire logic [15:0] stack_ptr_i,
  input wire logic [15:0] store_data_i,
  input wire logic [7:0] rmw_result_i,
  input wire logic [7:0] data_i,
  output iybcs_bus_t bus_o,
  output logic busy_o,
  output logic [3:0] cycle_o,
  output logic done_o,
  output logic fault_o,
  output logic pc_load_o,
  output logic [15:0] next_pc_o,
  output logic [15:0] operand_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  iybcs_state_t state_ff;
  iybcs_grp_t grp_ff;
  iybcs_bus_t bus_ff, nxt_bus;
  logic [3:0] cyc_ff, nxt_cyc;
  logic [15:0] pc_ff, sp_ff, ea_ff, operand_ff, ret_addr;
  logic [7:0] mask_ff, offset_ff, bit_result;
  logic op_lsb_ff, running, abort, finish, branch_taken, done_ff, fault_ff, pc_load_ff;
  logic [15:0] next_pc_ff, nxt_next_pc;
  logic nxt_pc_load;

  localparam iybcs_bus_t IDLE_BUS = '{addr: `IYBCS_IDLE_ADDR, rw: 1'b1, wdata: 8'h00, oe: 1'b0};

  assign running = (state_ff == ST_RUN);
  assign ret_addr = pc_ff + `IYBCS_STEP_SHORT;
  // A bad prebyte or an unknown second byte ends the sequence at once.
  assign abort = running && (((cyc_ff == 4'h1) && (data_i != `IYBCS_PREBYTE)) ||
                 ((cyc_ff == 4'h2) && (iybcs_decode(data_i) == GRP_BAD)));
  assign finish = running && (cyc_ff > 4'h3) && (cyc_ff == iybcs_len(grp_ff));
  assign bit_result = op_lsb_ff ? (operand_ff[7:0] & ~mask_ff) : (operand_ff[7:0] | mask_ff);
  assign branch_taken = op_lsb_ff ? ((operand_ff[7:0] & mask_ff) == 8'h00)
                                  : ((~operand_ff[7:0] & mask_ff) == 8'h00);

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      cyc_ff <= 4'h0;
    end else if (!running) begin
      if (start_i) begin
        state_ff <= ST_RUN;
        cyc_ff <= 4'h1;
      end
    end else if (abort || finish) begin
      state_ff <= ST_IDLE;
      cyc_ff <= 4'h0;
    end else begin
      cyc_ff <= nxt_cyc;
    end
  end

  // ****************************************************************
  // Instruction capture
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_ff <= 16'h0000;
      sp_ff <= 16'h0000;
      grp_ff <= GRP_BAD;
      op_lsb_ff <= 1'b0;
    end else if (!running && start_i) begin
      pc_ff <= pc_i;
      sp_ff <= stack_ptr_i;
      grp_ff <= GRP_BAD;
    end else if (running && cyc_ff == 4'h2) begin
      grp_ff <= iybcs_decode(data_i);
      op_lsb_ff <= data_i[0];
    end
  end

  // The sum is formed in cycle 3 as the offset byte arrives and held through the idle cycle, so cycle 5 can use it.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ea_ff <= 16'h0000;
    end else if (running && cyc_ff == 4'h3) begin
      ea_ff <= index_register_y_i + {8'h00, data_i};
    end
  end

  // ****************************************************************
  // Read data capture
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      operand_ff <= 16'h0000;
      mask_ff <= 8'h00;
      offset_ff <= 8'h00;
    end else if (running) begin
      case (cyc_ff)
        4'h5: begin
          if (grp_ff == GRP_LD16 || grp_ff == GRP_ALU16) begin
            operand_ff <= {data_i, 8'h00};
          end else if (grp_ff != GRP_ST8 && grp_ff != GRP_ST16) begin
            operand_ff <= {8'h00, data_i};
          end
        end
        4'h6: begin
          if (grp_ff == GRP_LD16 || grp_ff == GRP_ALU16) begin
            operand_ff[7:0] <= data_i;
          end else if (grp_ff == GRP_BITMOD || grp_ff == GRP_BRBIT) begin
            mask_ff <= data_i;
          end
        end
        4'h7: begin
          if (grp_ff == GRP_BRBIT) begin
            offset_ff <= data_i;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Next bus cycle
  // ****************************************************************
  always_comb begin
    nxt_cyc = cyc_ff + 4'h1;
    nxt_bus = IDLE_BUS;
    case (nxt_cyc)
      4'h2: nxt_bus.addr = pc_ff + 16'h0001;
      4'h3: nxt_bus.addr = pc_ff + 16'h0002;
      4'h5: begin
        nxt_bus.addr = ea_ff;
        if (grp_ff == GRP_ST8) begin
          nxt_bus = '{addr: ea_ff, rw: 1'b0, wdata: store_data_i[7:0], oe: 1'b1};
        end else if (grp_ff == GRP_ST16) begin
          nxt_bus = '{addr: ea_ff, rw: 1'b0, wdata: store_data_i[15:8], oe: 1'b1};
        end
      end
      4'h6: begin
        case (grp_ff)
          GRP_LD16, GRP_ALU16: nxt_bus.addr = ea_ff + 16'h0001;
          GRP_ST16: nxt_bus = '{addr: ea_ff + 16'h0001, rw: 1'b0, wdata: store_data_i[7:0], oe: 1'b1};
          GRP_CALL: nxt_bus = '{addr: sp_ff, rw: 1'b0, wdata: ret_addr[7:0], oe: 1'b1};
          GRP_BITMOD, GRP_BRBIT: nxt_bus.addr = pc_ff + `IYBCS_STEP_SHORT;
          default: nxt_bus = IDLE_BUS;
        endcase
      end
      4'h7: begin
        case (grp_ff)
          GRP_RMW: nxt_bus = '{addr: ea_ff, rw: 1'b0, wdata: rmw_result_i, oe: 1'b1};
          GRP_CALL: nxt_bus = '{addr: sp_ff - 16'h0001, rw: 1'b0, wdata: ret_addr[15:8], oe: 1'b1};
          GRP_BRBIT: nxt_bus.addr = pc_ff + `IYBCS_STEP_BITMOD;
          default: nxt_bus = IDLE_BUS;
        endcase
      end
      4'h8: begin
        if (grp_ff == GRP_BITMOD) begin
          nxt_bus = '{addr: ea_ff, rw: 1'b0, wdata: bit_result, oe: 1'b1};
        end
      end
      default: nxt_bus = IDLE_BUS;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_ff <= IDLE_BUS;
    end else if (!running) begin
      if (start_i) begin
        bus_ff <= '{addr: pc_i, rw: 1'b1, wdata: 8'h00, oe: 1'b0};
      end else begin
        bus_ff <= IDLE_BUS;
      end
    end else if (abort || finish) begin
      bus_ff <= IDLE_BUS;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  // ****************************************************************
  // Completion and program counter
  // ****************************************************************
  always_comb begin
    nxt_pc_load = 1'b0;
    nxt_next_pc = pc_ff + `IYBCS_STEP_SHORT;
    case (grp_ff)
      GRP_JUMP, GRP_CALL: begin
        nxt_pc_load = 1'b1;
        nxt_next_pc = ea_ff;
      end
      GRP_BITMOD: nxt_next_pc = pc_ff + `IYBCS_STEP_BITMOD;
      GRP_BRBIT: begin
        nxt_pc_load = branch_taken;
        nxt_next_pc = pc_ff + `IYBCS_STEP_BRANCH;
        if (branch_taken) begin
          nxt_next_pc = pc_ff + `IYBCS_STEP_BRANCH + {{8{offset_ff[7]}}, offset_ff};
        end
      end
      default: nxt_pc_load = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      pc_load_ff <= 1'b0;
      next_pc_ff <= 16'h0000;
    end else begin
      done_ff <= finish;
      fault_ff <= abort;
      pc_load_ff <= finish && nxt_pc_load;
      if (finish) begin
        next_pc_ff <= nxt_next_pc;
      end
    end
  end

  assign bus_o = bus_ff;
  // The run bit of the one-hot state drives the port, so no decode sits in front of it.
  assign busy_o = state_ff[1];
  assign cycle_o = cyc_ff;
  assign done_o = done_ff;
  assign fault_o = fault_ff;
  assign pc_load_o = pc_load_ff;
  assign next_pc_o = next_pc_ff;
  assign operand_o = operand_ff;

endmodule // iybcs_seq

`default_nettype wire

// >>> test/iybcs_seq_monitor.sv
// Port-timing checker of the indexed-Y bus-cycle sequencer.
// Sees only the sequencer's ports; attached by the bind below.
`timescale 1ns/1ns
`default_nettype none
module iybcs_seq_monitor
  import iybcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [15:0] pc_i,
  input wire iybcs_bus_t bus_o,
  input wire logic busy_o,
  input wire logic [3:0] cycle_o,
  input wire logic done_o,
  input wire logic fault_o
);
  logic [15:0] prv_addr_ff;
  logic prv_rw_ff;
  logic [3:0] prv_cyc_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prv_addr_ff <= 16'hffff;
      prv_rw_ff <= 1'b1;
      prv_cyc_ff <= 4'h0;
    end else begin
      prv_addr_ff <= bus_o.addr;
      prv_rw_ff <= bus_o.rw;
      prv_cyc_ff <= cycle_o;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_take;
    !busy_o && start_i && $past(reset_n_i) |=> cycle_o == 4'h1 && bus_o.addr == $past(pc_i) && bus_o.rw;
  endproperty
  a_take: assert property (p_take) else $error("first fetch not at opcode address");
  property p_fetch;
    cycle_o inside {4'h2, 4'h3} |-> bus_o.rw && bus_o.addr == prv_addr_ff + 16'h1 && prv_cyc_ff == cycle_o - 4'h1;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch bytes not consecutive");
  property p_idle;
    cycle_o == 4'h4 |-> bus_o.addr == 16'hffff && bus_o.rw;
  endproperty
  a_idle: assert property (p_idle) else $error("cycle 4 not an idle read");
  property p_after4;
    cycle_o == 4'h4 |=> cycle_o == 4'h5 || done_o;
  endproperty
  a_after4: assert property (p_after4) else $error("cycle 4 not followed by 5 or end");
  property p_end;
    done_o || fault_o |-> !busy_o && cycle_o == 4'h0 && bus_o.addr == 16'hffff;
  endproperty
  a_end: assert property (p_end) else $error("bus not idle after end");
  property p_len;
    done_o |-> prv_cyc_ff >= 4'h4 && prv_cyc_ff <= 4'h8;
  endproperty
  a_len: assert property (p_len) else $error("instruction length out of range");
  property p_wr;
    !bus_o.rw |-> cycle_o >= 4'h5 && bus_o.oe;
  endproperty
  a_wr: assert property (p_wr) else $error("write outside execute cycles");
  property p_pair;
    cycle_o == 4'h6 && !bus_o.rw && !prv_rw_ff |-> bus_o.addr == prv_addr_ff + 16'h1;
  endproperty
  a_pair: assert property (p_pair) else $error("low byte not at next address");
  property p_stk;
    cycle_o == 4'h7 && !bus_o.rw && !prv_rw_ff |-> bus_o.addr == prv_addr_ff - 16'h1;
  endproperty
  a_stk: assert property (p_stk) else $error("high return byte not below low");
endmodule // iybcs_seq_monitor
bind iybcs_seq iybcs_seq_monitor u_mon (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .pc_i(pc_i),
  .bus_o(bus_o), .busy_o(busy_o), .cycle_o(cycle_o), .done_o(done_o), .fault_o(fault_o));
`default_nettype wire

// >>> test/iybcs_mem_model.sv
// Memory on the far side of the sequencer's bus.
// Reads answer in the same cycle; writes land at the rising edge.
`timescale 1ns/1ns
`default_nettype none
module iybcs_mem_model
  import iybcs_pkg::*;
(
  input wire logic clk_i,
  input wire iybcs_bus_t bus_i,
  output logic [7:0] data_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end
  // Memory does not drive during a write, so the line must not keep a usable value.
  always_comb begin
    data_o = bus_i.rw ? mem[bus_i.addr] : ~last_ff;
  end
  always @(posedge clk_i) begin
    last_ff <= data_o;
    if (!bus_i.rw) begin
      mem[bus_i.addr] <= bus_i.wdata;
    end
  end
endmodule // iybcs_mem_model
`default_nettype wire

// >>> test/iybcs_seq_tb.sv
// Self-checking bench of the indexed-Y bus-cycle sequencer.
// Needs the package, the memory model and the checker compiled first.
`timescale 1ns/1ns
`default_nettype none
module iybcs_seq_tb import iybcs_pkg::*;;
  localparam logic [15:0] P = 16'h2000;
  localparam logic [15:0] Y = 16'h4000;
  localparam logic [15:0] EA = 16'h4010;
  localparam logic [15:0] SP = 16'h0100;
  localparam logic [15:0] ST = 16'hbeef;
  localparam logic [15:0] RET = 16'h2003;
  localparam logic [7:0] RMW = 8'h5a;
  logic clk_i, reset_n_i, start_i, busy_o, done_o, fault_o, pc_load_o;
  logic [15:0] pc_i, index_register_y_i, stack_ptr_i, store_data_i, next_pc_o, operand_o;
  logic [7:0] rmw_result_i, data_i, bit_res, pre;
  logic [3:0] cycle_o;
  iybcs_bus_t bus_o;
  int failures, n_compared;
  always #25 clk_i = ~clk_i;
  iybcs_seq u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .pc_i(pc_i),
    .index_register_y_i(index_register_y_i), .stack_ptr_i(stack_ptr_i), .store_data_i(store_data_i),
    .rmw_result_i(rmw_result_i), .data_i(data_i), .bus_o(bus_o), .busy_o(busy_o), .cycle_o(cycle_o),
    .done_o(done_o), .fault_o(fault_o), .pc_load_o(pc_load_o), .next_pc_o(next_pc_o), .operand_o(operand_o));
  iybcs_mem_model u_mem (.clk_i(clk_i), .bus_i(bus_o), .data_o(data_i));
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************************
  // One instruction; each letter of s is one bus cycle.
  // ****************************************************
  task automatic go(input logic [7:0] op, input string s, input logic ok);
    logic [15:0] a;
    logic [7:0] w;
    byte c;
    u_mem.mem[P] = pre;
    u_mem.mem[P + 16'h1] = op;
    u_mem.mem[P + 16'h2] = 8'h10;
    u_mem.mem[P + 16'h3] = 8'h82;
    u_mem.mem[P + 16'h4] = 8'h05;
    u_mem.mem[EA] = 8'h41;
    u_mem.mem[EA + 16'h1] = 8'h27;
    @(posedge clk_i);
    #2 start_i = 1'b1;
    @(posedge clk_i);
    #2 start_i = 1'b0;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      case (c)
        "F": a = 16'hffff;
        "E", "H", "B", "R", "M": a = EA;
        "e", "L": a = EA + 16'h1;
        "S": a = SP;
        "s": a = SP - 16'h1;
        default: a = P + {12'h0, c[3:0]};
      endcase
      case (c)
        "H": w = ST[15:8];
        "L", "B": w = ST[7:0];
        "R": w = RMW;
        "M": w = bit_res;
        "S": w = RET[7:0];
        "s": w = RET[15:8];
        default: w = 8'h00;
      endcase
      cmp("addr", a, bus_o.addr);
      cmp("rw", {15'h0, !(c inside {"H", "L", "B", "R", "M", "S", "s"})}, {15'h0, bus_o.rw});
      cmp("busy", 16'h1, {15'h0, busy_o});
      cmp("cycle", 16'(i + 1), {12'h0, cycle_o});
      if (c inside {"H", "L", "B", "R", "M", "S", "s"}) cmp("wdata", {8'h0, w}, {8'h0, bus_o.wdata});
      @(posedge clk_i);
      #2;
    end
    cmp(ok ? "done" : "fault", 16'h1, {15'h0, ok ? done_o : fault_o});
    cmp("busy", 16'h0, {15'h0, busy_o});
  endtask
  task automatic t_jump;
    go(8'h6e, "012F", 1'b1);
    cmp("next_pc", EA, next_pc_o);
    cmp("pc_load", 16'h1, {15'h0, pc_load_o});
  endtask
  task automatic t_short;
    go(8'ha6, "012FE", 1'b1);
    cmp("operand", 16'h0041, {8'h0, operand_o[7:0]});
    go(8'ha7, "012FB", 1'b1);
  endtask
  task automatic t_long;
    go(8'h6c, "012FEFR", 1'b1);
    go(8'h6d, "012FEFF", 1'b1);
    go(8'he3, "012FEeF", 1'b1);
  endtask
  task automatic t_word;
    go(8'hec, "012FEe", 1'b1);
    cmp("operand", 16'h4127, operand_o);
    go(8'hed, "012FHL", 1'b1);
  endtask
  task automatic t_call;
    go(8'had, "012FESs", 1'b1);
    cmp("next_pc", EA, next_pc_o);
    cmp("pc_load", 16'h1, {15'h0, pc_load_o});
  endtask
  task automatic t_bits;
    bit_res = 8'hc3;
    go(8'h1c, "012FE3FM", 1'b1);
    bit_res = 8'h41;
    go(8'h1d, "012FE3FM", 1'b1);
    cmp("next_pc", P + 16'h4, next_pc_o);
    go(8'h1e, "012FE34F", 1'b1);
    cmp("next_pc", P + 16'h5, next_pc_o);
    cmp("pc_load", 16'h0, {15'h0, pc_load_o});
    go(8'h1f, "012FE34F", 1'b1);
    cmp("next_pc", P + 16'ha, next_pc_o);
    cmp("pc_load", 16'h1, {15'h0, pc_load_o});
    go(8'h00, "01", 1'b0);
    pre = 8'h1a;
    go(8'h6e, "0", 1'b0);
    pre = 8'h18;
  endtask
  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    start_i = 1'b0;
    pc_i = P;
    index_register_y_i = Y;
    stack_ptr_i = SP;
    store_data_i = ST;
    rmw_result_i = RMW;
    bit_res = 8'h00;
    pre = 8'h18;
    failures = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_i);
    #2 reset_n_i = 1'b1;
    t_jump;
    t_short;
    t_long;
    t_word;
    t_call;
    t_bits;
    conclude;
  end
  // The whole sequence needs about 120 cycles; allow well over ten times that.
  initial begin
    #100000;
    failures++;
    conclude;
  end
endmodule // iybcs_seq_tb
`default_nettype wire
